// *** rtl/dim_pkg.sv ***
// Purpose: Shared constants and types for the digital input/output mapper.
// Assumes: 250 MHz system clock, parameter writes arrive as one-cycle strobes.
// Notes: Parameter codes are local indices used on the parameter write port.
package dim_pkg;

  // ==========================================================================
  // Sizes.
  localparam int NUM_IN = 5;          // Assignable input terminals.
  localparam int NUM_OUT = 13;        // Assignable outputs, relay included.
  localparam int NUM_PIN_OUT = 6;     // Five output terminals plus the relay.
  localparam int FUNC_W = 6;          // Input function code width.
  localparam int SIG_W = 5;           // Output function code width.
  localparam int DLY_W = 18;          // Delay width in milliseconds.

  // ==========================================================================
  // Parameter codes on the write port.
  localparam logic [3:0] CODE_INPUT_SELECT = 4'h0;
  localparam logic [3:0] CODE_INPUT_FUNCTION = 4'h1;
  localparam logic [3:0] CODE_INPUT_POLARITY = 4'h2;
  localparam logic [3:0] CODE_INPUT_PRIORITY = 4'h3;
  localparam logic [3:0] CODE_OUTPUT_SELECT = 4'h4;
  localparam logic [3:0] CODE_OUTPUT_FUNCTION = 4'h5;
  localparam logic [3:0] CODE_OUTPUT_POLARITY = 4'h6;
  localparam logic [3:0] CODE_OUTPUT_DELAY = 4'h7;

  // ==========================================================================
  // Input functions that may sit on several terminals at once.
  localparam logic [5:0] FN_NONE = 6'h00;
  localparam logic [5:0] FN_RAMP_TIMES = 6'h01;
  localparam logic [5:0] FN_JOG = 6'h02;
  localparam logic [5:0] FN_PAR_SET = 6'h14;
  localparam logic [5:0] FN_FIXED_SET = 6'h28;

  // ==========================================================================
  // Reset values and limits.
  localparam logic [2:0] IN_SEL_RST = 3'h1;
  localparam logic [3:0] OUT_SEL_RST = 4'h1;
  localparam logic [3:0] OUT_SEL_RELAY = 4'hD;
  localparam logic [3:0] OUT_SEL_LAST_TERM = 4'h5;
  localparam logic [17:0] DLY_RST = 18'h00000;
  localparam logic [17:0] DLY_MAX_MS = 18'h3A980;  // 240.000 s in 1 ms steps.

  // ==========================================================================
  // Timing: the delay resolution is one millisecond.
  localparam int CLK_PERIOD_PS = 4000;
  localparam int DLY_STEP_PS = 1000000000;
  localparam int TICK_CYCLES = DLY_STEP_PS / CLK_PERIOD_PS;

  // ==========================================================================
  // One parameter write.
  typedef struct packed {
    logic wr;
    logic [3:0] code;
    logic [17:0] data;
  } dim_par_wr_t;

endpackage : dim_pkg

// *** rtl/dim_out_delay.sv ***
// Purpose: Delays one output level by a programmable count of millisecond ticks.
// Assumes: tick_in pulses once per millisecond for one cycle.
// Notes: A level must hold for the whole delay; any change restarts the count.
`timescale 1ns/100ps
`default_nettype none

module dim_out_delay (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Timing.
  input wire logic tick_in,
  input wire logic [17:0] delay_in,
  // Level.
  input wire logic lvl_in,
  output logic lvl_out
);

  logic out_r;             // Delayed level.
  logic [17:0] cnt_r;      // Milliseconds the new level has held.
  wire differs = lvl_in != out_r;
  // The count must pass the setting: the shared tick may arrive just after a change, so
  // stopping at equality could let a level through almost a millisecond early.
  wire expired = (delay_in == dim_pkg::DLY_RST) || (cnt_r > delay_in);

  // ==========================================================================
  // Hold counter; a return to the old level clears it, which is the restart.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      out_r <= 1'b0;
      cnt_r <= dim_pkg::DLY_RST;
    end else if (!differs) begin
      cnt_r <= dim_pkg::DLY_RST;
    end else if (expired) begin
      out_r <= lvl_in;
      cnt_r <= dim_pkg::DLY_RST;
    end else if (tick_in) begin
      cnt_r <= cnt_r + 18'h00001;
    end
  end

  assign lvl_out = out_r;

  // ==========================================================================
  // Checks.
  AST_ZERO_DELAY: assert property (@(posedge clk_in) disable iff (rst_in)
    (differs && delay_in == dim_pkg::DLY_RST) |=> (out_r == $past(lvl_in)))
    else $error("zero delay did not pass the level in one cycle");
  AST_HOLD_FIRST: assert property (@(posedge clk_in) disable iff (rst_in)
    $changed(out_r) |-> ($past(lvl_in) == out_r
      && ($past(delay_in) == dim_pkg::DLY_RST || $past(cnt_r) > $past(delay_in))))
    else $error("output changed before the delay elapsed");

endmodule : dim_out_delay

`default_nettype wire

// *** rtl/dim_top.sv ***
// Purpose: Maps assignable digital inputs and outputs of a speed controller.
// Assumes: Terminal inputs are synchronous; settings arrive as one-cycle writes.
// Notes: Output pin delays run on a 1 ms tick divided from the system clock.
`timescale 1ns/100ps
`default_nettype none

module dim_top #(
  parameter int TICK_CYCLES = dim_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  // Input terminals and control source.
  input wire logic [4:0] IN_TERM_IN,
  input wire logic TERM_CTRL_EN_IN,
  // Internal signals selectable by output functions; bit 0 is unused.
  input wire logic [31:0] SIG_IN,
  // Serial parameter interface.
  input wire dim_pkg::dim_par_wr_t PAR_WR_IN,
  output logic PAR_REFUSED_OUT,
  output logic [15:0] INPUT_STATE_OUT,
  output logic [15:0] OUTPUT_STATE_OUT,
  // Input function results.
  output logic [4:0] TERM_ACTIVE_OUT,
  output logic [63:0] FUNC_REQ_OUT,
  // Output terminals and relay contacts.
  output logic [4:0] OUT_TERM_OUT,
  output logic RELAY_OUT
);

  // ==========================================================================
  // Settings.
  logic [2:0] in_sel_r;                       // Selected input, 1..5.
  logic [5:0] in_func_r [dim_pkg::NUM_IN];    // Function per input.
  logic [4:0] in_pol_r;                       // One means low-active.
  logic [4:0] prio_r;                         // One keeps the function alive.
  logic [3:0] out_sel_r;                      // Selected output, 1..13.
  logic [4:0] out_func_r [dim_pkg::NUM_OUT];  // Signal per output.
  logic [5:0] out_pol_r;                      // Pin inversion, relay at bit 5.
  logic [17:0] dly_r [dim_pkg::NUM_PIN_OUT];  // Pin delay in milliseconds.

  // ==========================================================================
  // Status and pins.
  logic refused_r; // One-cycle pulse after a refused write.
  logic [4:0] in_state_r; // Inputs after polarity.
  logic [12:0] out_state_r; // Active-high output states.
  logic [4:0] term_act_r; // Terminals whose function is live.
  logic [63:0] func_req_r; // Registered function requests.
  logic [5:0] pin_r; // Pin levels after inversion, relay at bit 5.
  logic [17:0] tick_cnt_r; // Divider toward the millisecond tick.
  logic tick_r; // One-cycle millisecond tick.
  logic [5:0] dly_lvl; // Delayed levels, relay at bit 5.

  // ==========================================================================
  // Write decode. Only legal indices are stored; others are refused.
  // Index codes act on the current selection, so the host must select first.
  wire wr = PAR_WR_IN.wr;
  wire [17:0] wdata = PAR_WR_IN.data;
  wire wr_in_sel = wr && PAR_WR_IN.code == dim_pkg::CODE_INPUT_SELECT;
  wire wr_in_func = wr && PAR_WR_IN.code == dim_pkg::CODE_INPUT_FUNCTION;
  wire wr_in_pol = wr && PAR_WR_IN.code == dim_pkg::CODE_INPUT_POLARITY;
  wire wr_prio = wr && PAR_WR_IN.code == dim_pkg::CODE_INPUT_PRIORITY;
  wire wr_out_sel = wr && PAR_WR_IN.code == dim_pkg::CODE_OUTPUT_SELECT;
  wire wr_out_func = wr && PAR_WR_IN.code == dim_pkg::CODE_OUTPUT_FUNCTION;
  wire wr_out_pol = wr && PAR_WR_IN.code == dim_pkg::CODE_OUTPUT_POLARITY;
  wire wr_dly = wr && PAR_WR_IN.code == dim_pkg::CODE_OUTPUT_DELAY;
  wire [2:0] in_idx = in_sel_r - 3'h1;
  wire [3:0] out_idx = out_sel_r - 4'h1;
  // Range checks on the incoming data word.
  wire in_sel_ok = wdata >= 18'h00001 && wdata <= 18'h00005;
  wire out_sel_ok = wdata >= 18'h00001 && wdata <= 18'h0000D;
  wire [5:0] new_fn = wdata[5:0];
  wire fn_ok = wdata <= 18'h0003F;
  wire sig_ok = wdata <= 18'h0001F;
  // Polarity and delay exist only for the five terminals and the relay.
  wire out_has_pin = out_sel_r <= dim_pkg::OUT_SEL_LAST_TERM
    || out_sel_r == dim_pkg::OUT_SEL_RELAY;
  wire [2:0] pin_idx = (out_sel_r == dim_pkg::OUT_SEL_RELAY) ? 3'h5 : out_idx[2:0];
  // Jog, ramp times, fixed set-values and parameter set may repeat.
  wire fn_multi = new_fn == dim_pkg::FN_NONE || new_fn == dim_pkg::FN_RAMP_TIMES
    || new_fn == dim_pkg::FN_JOG || new_fn == dim_pkg::FN_PAR_SET
    || new_fn == dim_pkg::FN_FIXED_SET;
  logic [4:0] held_elsewhere;  // Another terminal already holds new_fn.
  wire fn_taken = !fn_multi && held_elsewhere != 5'h00;
  wire fn_accept = wr_in_func && fn_ok && !fn_taken;
  // A delay past the limit is refused, not clipped, so a mistyped value never runs long.
  wire dly_ok = wdata <= dim_pkg::DLY_MAX_MS;
  // Every refusal reason in one place; the status pulse follows one cycle later.
  wire refuse = (wr_in_sel && !in_sel_ok) || (wr_in_func && (!fn_ok || fn_taken))
    || (wr_out_sel && !out_sel_ok) || (wr_out_func && !sig_ok)
    || ((wr_out_pol || wr_dly) && !out_has_pin) || (wr_dly && !dly_ok);

  // ==========================================================================
  // Per-input logic: ownership test, polarity and priority gating.
  wire [4:0] asserted = IN_TERM_IN ^ in_pol_r;
  wire [4:0] term_eff = asserted & (prio_r | {5{TERM_CTRL_EN_IN}});
  logic [63:0] func_req; // Request vector ahead of its status register.
  genvar gi;
  generate
    for (gi = 0; gi < dim_pkg::NUM_IN; gi++) begin : g_in
      assign held_elsewhere[gi] = (3'(gi) != in_idx) && (in_func_r[gi] == new_fn);
    end
  endgenerate

  // A function request is the OR of all effective terminals carrying it.
  always_comb begin
    func_req = 64'h0000000000000000;
    for (int i = 0; i < dim_pkg::NUM_IN; i++) begin
      if (term_eff[i]) begin
        func_req[in_func_r[i]] = 1'b1;
      end
    end
    func_req[0] = 1'b0;  // Function zero does nothing.
  end

  // ==========================================================================
  // Per-output logic: signal selection and the delayed pins.
  logic [12:0] out_act;
  generate
    for (gi = 0; gi < dim_pkg::NUM_OUT; gi++) begin : g_out
      // Internal view is always active-high, whatever the pin inversion.
      assign out_act[gi] = (out_func_r[gi] != 5'h00) && SIG_IN[out_func_r[gi]];
    end
    // Pins 0 to 4 carry outputs 1 to 5; pin 5, the relay, carries output 13.
    for (gi = 0; gi < dim_pkg::NUM_PIN_OUT; gi++) begin : g_pin
      localparam int SRC = (gi == 5) ? 12 : gi;
      dim_out_delay u_dly (
        .clk_in(CLK_SYS_IN),
        .rst_in(RST_IN),
        .tick_in(tick_r),
        .delay_in(dly_r[gi]),
        .lvl_in(out_act[SRC]),
        .lvl_out(dly_lvl[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Settings registers; a refused write leaves every setting untouched.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      in_sel_r <= dim_pkg::IN_SEL_RST;
      in_pol_r <= 5'h00;
      prio_r <= 5'h00;
      out_sel_r <= dim_pkg::OUT_SEL_RST;
      out_pol_r <= 6'h00;
      for (int i = 0; i < dim_pkg::NUM_IN; i++) begin
        in_func_r[i] <= dim_pkg::FN_NONE;
      end
      for (int i = 0; i < dim_pkg::NUM_OUT; i++) begin
        out_func_r[i] <= 5'h00;
      end
      for (int i = 0; i < dim_pkg::NUM_PIN_OUT; i++) begin
        dly_r[i] <= dim_pkg::DLY_RST;
      end
    end else begin
      if (wr_in_sel && in_sel_ok) begin
        in_sel_r <= wdata[2:0];
      end
      // A stored function replaces the old one; nothing else remembers it.
      if (fn_accept) begin
        in_func_r[in_idx] <= new_fn;
      end
      // Polarity and priority take effect on the very next input sample.
      if (wr_in_pol) begin
        in_pol_r[in_idx] <= wdata[0];
      end
      if (wr_prio) begin
        prio_r[in_idx] <= wdata[0];
      end
      if (wr_out_sel && out_sel_ok) begin
        out_sel_r <= wdata[3:0];
      end
      if (wr_out_func && sig_ok) begin
        out_func_r[out_idx] <= wdata[4:0];
      end
      if (wr_out_pol && out_has_pin) begin
        out_pol_r[pin_idx] <= wdata[0];
      end
      if (wr_dly && out_has_pin && dly_ok) begin
        dly_r[pin_idx] <= wdata;
      end
    end
  end

  // ==========================================================================
  // Millisecond tick. A free-running divider keeps all pins on one grid.
  // Trade-off: one divider instead of six makes the first step of a delay partial;
  // each delay stage counts one step past its setting to make up for it.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      tick_cnt_r <= 18'h00000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= tick_cnt_r == 18'(TICK_CYCLES - 1);
      tick_cnt_r <= (tick_cnt_r == 18'(TICK_CYCLES - 1)) ? 18'h00000
        : tick_cnt_r + 18'h00001;
    end
  end

  // ==========================================================================
  // Status words, function results and pin levels.
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      refused_r <= 1'b0;
      in_state_r <= 5'h00;
      out_state_r <= 13'h0000;
      term_act_r <= 5'h00;
      func_req_r <= 64'h0000000000000000;
      pin_r <= 6'h00;
    end else begin
      refused_r <= refuse;
      in_state_r <= asserted;
      out_state_r <= out_act;
      term_act_r <= term_eff;
      func_req_r <= func_req;
      pin_r <= dly_lvl ^ out_pol_r;
    end
  end

  // Upper status bits are tied low so a full sixteen-bit read shows no stale data.
  assign PAR_REFUSED_OUT = refused_r;
  assign INPUT_STATE_OUT = {11'h000, in_state_r};
  assign OUTPUT_STATE_OUT = {3'h0, out_state_r};
  assign TERM_ACTIVE_OUT = term_act_r;
  assign FUNC_REQ_OUT = func_req_r;
  assign OUT_TERM_OUT = pin_r[4:0];
  assign RELAY_OUT = pin_r[5];

  // ==========================================================================
  // Checks.
  // Named steps of the refused-move check: a write of a held function, then no change.
  sequence s_taken_write;
    wr_in_func && fn_ok && !fn_multi && held_elsewhere != 5'h00;
  endsequence
  sequence s_refused_unchanged;
    PAR_REFUSED_OUT && in_func_r[$past(in_idx)] == $past(in_func_r[in_idx]);
  endsequence

  AST_PRIO0_IGNORED: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    !TERM_CTRL_EN_IN |=> ((TERM_ACTIVE_OUT & ~$past(prio_r)) == 5'h00))
    else $error("priority zero input active with terminal control off");
  AST_PRIO1_KEPT: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    1'b1 |=> ((TERM_ACTIVE_OUT & $past(prio_r)) == ($past(asserted) & $past(prio_r))))
    else $error("priority one input not kept active");
  AST_IN_WORD: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    1'b1 |=> (INPUT_STATE_OUT == {11'h000, $past(IN_TERM_IN) ^ $past(in_pol_r)}))
    else $error("input state word wrong");
  AST_TAKEN_REFUSED: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    s_taken_write |=> s_refused_unchanged)
    else $error("single function moved while still held");
  AST_OVERWRITE: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    fn_accept |=> (in_func_r[$past(in_idx)] == $past(new_fn) && !PAR_REFUSED_OUT))
    else $error("new input function not stored");
  AST_OUT_WORD: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    1'b1 |=> (OUTPUT_STATE_OUT == {3'h0, $past(out_act)}))
    else $error("output state word wrong");
  AST_INVERT: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    1'b1 |=> (RELAY_OUT == ($past(dly_lvl[5]) ^ $past(out_pol_r[5]))))
    else $error("relay level not inverted per setting");
  AST_DLY_LIMIT: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    (wr_dly && !dly_ok) |=> (PAR_REFUSED_OUT && $stable(dly_r[5]) && $stable(dly_r[0])))
    else $error("delay above limit accepted");
  AST_TICK_GAP: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    tick_r |=> !tick_r)
    else $error("millisecond tick longer than one cycle");
  // An out-of-range select is refused and leaves the old selection in place.
  AST_OUT_SEL_RANGE: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    (wr_out_sel && !out_sel_ok) |=> (PAR_REFUSED_OUT && $stable(out_sel_r)))
    else $error("output select beyond thirteen accepted");
  // Internal-only outputs have neither polarity nor delay.
  AST_PIN_ONLY: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    ((wr_out_pol || wr_dly) && !out_has_pin) |=> PAR_REFUSED_OUT)
    else $error("polarity or delay accepted for an internal output");
  // Repeatable functions are never refused for being held elsewhere.
  AST_MULTI_OK: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    (wr_in_func && fn_ok && fn_multi) |=> !PAR_REFUSED_OUT)
    else $error("repeatable input function refused");
  // Terminal pins follow the delayed level, inverted per setting.
  AST_TERM_INVERT: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
    1'b1 |=> (OUT_TERM_OUT == ($past(dly_lvl[4:0]) ^ $past(out_pol_r[4:0]))))
    else $error("terminal level not inverted per setting");

endmodule : dim_top

`default_nettype wire

// *** tb/dim_plc_model.sv ***
// Purpose: Behavioural stand-in for the PLC that drives the input terminals.
// Assumes: Terminal levels are requested by the bench and settle on a clock edge.
// Notes: The PLC contacts are synchronous here, so no debounce is modelled.
`timescale 1ns/100ps
`default_nettype none

module dim_plc_model (
  // Clock.
  input wire logic clk_in,
  // Requested contact levels from the bench.
  input wire logic [4:0] lvl_req_in,
  // Terminal levels seen by the mapper.
  output logic [4:0] term_out
);
  // ==========================================================================
  // Contact drive.
  // Levels move on the rising edge with a non-blocking update.
  // This keeps the bench's falling-edge writes free of races.
  always @(posedge clk_in) begin
    term_out <= lvl_req_in;
  end
endmodule : dim_plc_model
`default_nettype wire

// *** tb/dim_top_tb_top.sv ***
// Purpose: Self-checking bench for the digital input/output mapper.
// Assumes: A short millisecond tick so that output delays finish quickly.
// Notes: Inputs change on the falling edge; outputs are read there too.
`timescale 1ns/100ps
`default_nettype none

module dim_top_tb_top;
  // ==========================================================================
  // Stimulus and observation signals.
  localparam int TK = 4;  // Clock cycles per simulated millisecond.
  logic clk_sys = 1'b0;  // System clock.
  logic rst = 1'b1;  // Synchronous reset.
  logic [4:0] lvl_req = 5'h00;  // Contact levels asked of the PLC.
  logic [4:0] in_term;  // Terminal levels from the PLC model.
  logic term_en = 1'b1;  // Control source allows terminal control.
  logic [31:0] sig = 32'h00000000;  // Internal signals for output functions.
  dim_pkg::dim_par_wr_t par = '0;  // Parameter write strobe.
  logic refused;
  logic [15:0] in_state;
  logic [15:0] out_state;
  logic [4:0] term_act;
  logic [63:0] func_req;
  logic [4:0] out_term;
  logic relay;
  int fails = 0;
  int num_checks = 0;

  // Clock at 250 MHz.
  always #2 clk_sys = ~clk_sys;

  dim_plc_model plc (.clk_in(clk_sys), .lvl_req_in(lvl_req), .term_out(in_term));

  dim_top #(.TICK_CYCLES(TK)) uut (
    .CLK_SYS_IN(clk_sys), .RST_IN(rst), .IN_TERM_IN(in_term), .TERM_CTRL_EN_IN(term_en),
    .SIG_IN(sig), .PAR_WR_IN(par), .PAR_REFUSED_OUT(refused), .INPUT_STATE_OUT(in_state),
    .OUTPUT_STATE_OUT(out_state), .TERM_ACTIVE_OUT(term_act), .FUNC_REQ_OUT(func_req),
    .OUT_TERM_OUT(out_term), .RELAY_OUT(relay)
  );

  // ==========================================================================
  // Shared tasks.
  // Prints the verdict and stops the run.
  task automatic end_of_test();
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  // Compares one observed value with its expectation.
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Waits a number of falling edges.
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick

  // One parameter write; the refusal pulse is caught over the two cycles after it.
  task automatic wr(input logic [3:0] c, input logic [17:0] d, input logic exp_ref);
    logic seen;
    @(negedge clk_sys);
    par.wr = 1'b1;
    par.code = c;
    par.data = d;
    @(negedge clk_sys);
    par.wr = 1'b0;
    seen = refused;
    @(negedge clk_sys);
    seen = seen | refused;
    chk("par_refused", seen, exp_ref);
  endtask : wr

  // Configures one output in host order: index, function, polarity, delay.
  task automatic cfg_out(input logic [17:0] idx, fn, pol, dly);
    wr(dim_pkg::CODE_OUTPUT_SELECT, idx, 1'b0);
    wr(dim_pkg::CODE_OUTPUT_FUNCTION, fn, 1'b0);
    wr(dim_pkg::CODE_OUTPUT_POLARITY, pol, 1'b0);
    wr(dim_pkg::CODE_OUTPUT_DELAY, dly, 1'b0);
  endtask : cfg_out

  // Bounded wait for an output terminal to reach a level; a timeout ends the run.
  task automatic wait_pin(input int b, input logic v, input int n);
    int k;
    for (k = 0; k < n && out_term[b] !== v; k++) tick(1);
    chk("out_term", out_term[b], v);
    if (out_term[b] !== v) end_of_test();
  endtask : wait_pin

  // ==========================================================================
  // Main sequence.
  initial begin : main_seq
    logic lost;
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    tick(2);
    // Everything reads idle straight out of reset.
    chk("in_state", in_state, 16'h0000);
    chk("out_state", out_state, 16'h0000);
    chk("pins", {relay, out_term}, 6'h00);
    // Low-active input 2 reads one while its contact is open.
    wr(dim_pkg::CODE_INPUT_SELECT, 18'h00002, 1'b0);
    wr(dim_pkg::CODE_INPUT_POLARITY, 18'h00001, 1'b0);
    tick(3);
    chk("in_state", in_state, 16'h0002);
    lvl_req = 5'h12;
    tick(4);
    chk("in_state", in_state, 16'h0010);
    // Priority zero: terminal control off masks the function.
    wr(dim_pkg::CODE_INPUT_SELECT, 18'h00001, 1'b0);
    wr(dim_pkg::CODE_INPUT_FUNCTION, 18'h00004, 1'b0);
    lvl_req = 5'h01;
    term_en = 1'b0;
    tick(4);
    chk("term_active", term_act[0], 1'b0);
    chk("func_req", func_req[4], 1'b0);
    term_en = 1'b1;
    tick(3);
    chk("func_req", func_req[4], 1'b1);
    // Priority one keeps the function alive with terminal control off.
    term_en = 1'b0;
    wr(dim_pkg::CODE_INPUT_PRIORITY, 18'h00001, 1'b0);
    tick(3);
    chk("func_req", func_req[4], 1'b1);
    // A taken function cannot move; repeatable ones may sit on two terminals.
    wr(dim_pkg::CODE_INPUT_SELECT, 18'h00003, 1'b0);
    wr(dim_pkg::CODE_INPUT_FUNCTION, 18'h00004, 1'b1);
    wr(dim_pkg::CODE_INPUT_FUNCTION, {12'h000, dim_pkg::FN_JOG}, 1'b0);
    wr(dim_pkg::CODE_INPUT_SELECT, 18'h00004, 1'b0);
    wr(dim_pkg::CODE_INPUT_FUNCTION, {12'h000, dim_pkg::FN_JOG}, 1'b0);
    // Clearing the holder overwrites its function and frees it for input 3.
    wr(dim_pkg::CODE_INPUT_SELECT, 18'h00001, 1'b0);
    wr(dim_pkg::CODE_INPUT_FUNCTION, 18'h00000, 1'b0);
    tick(3);
    chk("func_req", func_req[4], 1'b0);
    wr(dim_pkg::CODE_INPUT_SELECT, 18'h00003, 1'b0);
    wr(dim_pkg::CODE_INPUT_FUNCTION, 18'h00004, 1'b0);
    term_en = 1'b1;
    lvl_req = 5'h04;
    tick(4);
    chk("func_req", func_req[4], 1'b1);
    chk("func_req_none", func_req[0], 1'b0);
    // Only thirteen outputs exist.
    wr(dim_pkg::CODE_OUTPUT_SELECT, 18'h0000E, 1'b1);
    // Inverted relay: the pin flips but the serial view stays active-high.
    cfg_out(18'h0000D, 18'h00005, 18'h00001, 18'h00000);
    tick(4);
    chk("relay", relay, 1'b1);
    chk("out_state", out_state, 16'h0000);
    sig[5] = 1'b1;
    tick(4);
    chk("out_state", out_state, 16'h1000);
    chk("relay", relay, 1'b0);
    // Internal output 6 takes no polarity and no delay.
    wr(dim_pkg::CODE_OUTPUT_SELECT, 18'h00006, 1'b0);
    wr(dim_pkg::CODE_OUTPUT_FUNCTION, 18'h00003, 1'b0);
    wr(dim_pkg::CODE_OUTPUT_POLARITY, 18'h00001, 1'b1);
    wr(dim_pkg::CODE_OUTPUT_DELAY, 18'h00005, 1'b1);
    sig[3] = 1'b1;
    tick(3);
    chk("out_state", out_state, 16'h1020);
    // Delay limits: one step past the maximum is refused, the maximum taken.
    wr(dim_pkg::CODE_OUTPUT_SELECT, 18'h00001, 1'b0);
    wr(dim_pkg::CODE_OUTPUT_DELAY, 18'h3A981, 1'b1);
    cfg_out(18'h00001, 18'h00007, 18'h00000, dim_pkg::DLY_MAX_MS);
    wr(dim_pkg::CODE_OUTPUT_DELAY, 18'h00003, 1'b0);
    // Three steps of delay are twelve cycles here; after eleven the pin is still low.
    sig[7] = 1'b1;
    tick(3);
    chk("out_state", out_state, 16'h1021);
    tick(8);
    chk("out_term", out_term[0], 1'b0);
    wait_pin(0, 1'b1, 40);
    // A two-cycle drop is shorter than the delay and must not reach the pin.
    sig[7] = 1'b0;
    tick(2);
    sig[7] = 1'b1;
    lost = 1'b0;
    repeat (16) begin
      tick(1);
      lost = lost | (out_term[0] !== 1'b1);
    end
    chk("out_term_glitch", lost, 1'b0);
    sig[7] = 1'b0;
    wait_pin(0, 1'b0, 40);
    end_of_test();
  end : main_seq
endmodule : dim_top_tb_top
`default_nettype wire
